/* rtl/ictd_pkg.sv */
// Purpose: constants and types for the clock/io transfer decoder
// Assumes: ten-bit instruction words, 4-bit accumulator
// Notes: register offsets are byte addresses on the AXI4-Lite bus
package ictd_pkg;

    // ==========================================================
    // instruction codes
    localparam logic [9:0] OP_READ_WAKEUP_CTL0 = 10'h256;
    localparam logic [9:0] OP_WRITE_WAKEUP_CTL0 = 10'h21B;
    localparam logic [9:0] OP_READ_WAKEUP_CTL1 = 10'h259;
    localparam logic [9:0] OP_WRITE_WAKEUP_CTL1 = 10'h214;
    localparam logic [9:0] OP_READ_WAKEUP_CTL2 = 10'h25A;
    localparam logic [9:0] OP_WRITE_WAKEUP_CTL2 = 10'h215;
    localparam logic [9:0] OP_WRITE_OUT_FORMAT0 = 10'h228;
    localparam logic [9:0] OP_WRITE_OUT_FORMAT1 = 10'h229;
    localparam logic [9:0] OP_WRITE_OUT_FORMAT2 = 10'h22A;
    localparam logic [9:0] OP_WRITE_OUT_FORMAT3 = 10'h22B;
    localparam logic [9:0] OP_SELECT_CERAMIC_OSC = 10'h29A;
    localparam logic [9:0] OP_SELECT_RC_OSC = 10'h29B;
    localparam logic [9:0] OP_SELECT_QUARTZ_OSC = 10'h29D;
    localparam logic [9:0] OP_WRITE_CLOCK_GATE_BIT = 10'h209;
    localparam logic [9:0] OP_READ_CLOCK_DIVISION = 10'h252;
    localparam logic [9:0] OP_WRITE_CLOCK_DIVISION = 10'h216;

    // ==========================================================
    // oscillator selection codes
    localparam logic [1:0] OSC_CERAMIC = 2'h0;
    localparam logic [1:0] OSC_RC = 2'h1;
    localparam logic [1:0] OSC_QUARTZ = 2'h2;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] REG_WAKEUP_CTL0 = 8'h00;
    localparam logic [7:0] REG_WAKEUP_CTL1 = 8'h04;
    localparam logic [7:0] REG_WAKEUP_CTL2 = 8'h08;
    localparam logic [7:0] REG_OUT_FORMAT0 = 8'h0C;
    localparam logic [7:0] REG_OUT_FORMAT1 = 8'h10;
    localparam logic [7:0] REG_OUT_FORMAT2 = 8'h14;
    localparam logic [7:0] REG_OUT_FORMAT3 = 8'h18;
    localparam logic [7:0] REG_CLOCK_CTL = 8'h1C;
    localparam logic [7:0] REG_STATUS = 8'h20;

    // ==========================================================
    // reset values and field positions
    localparam logic [3:0] NIBBLE_RESET = 4'h0;
    localparam logic [1:0] OSC_RESET = 2'h0;
    localparam logic CLOCK_GATE_RESET = 1'b0;
    localparam int CLK_DIV_LSB = 0;
    localparam int CLK_GATE_BIT = 4;
    localparam int OSC_SEL_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // carried groups
    typedef struct packed {
        logic [3:0] wakeup_ctl0;
        logic [3:0] wakeup_ctl1;
        logic [3:0] wakeup_ctl2;
    } ictd_wakeup_t;

    typedef struct packed {
        logic [3:0] out_format0;
        logic [3:0] out_format1;
        logic [3:0] out_format2;
        logic [3:0] out_format3;
    } ictd_format_t;

    typedef struct packed {
        logic [3:0] clock_division_ctl;
        logic clock_gate_ctl;
        logic [1:0] osc_select;
    } ictd_clock_t;

endpackage

/* rtl/ictd_decoder.sv */
// Purpose: decode and execute the io / clock transfer instruction group
// Assumes: core presents one instruction per cycle with a strobe
// Notes: registers also visible read-only over AXI4-Lite
`timescale 1ns/100ps

module ictd_decoder
    import ictd_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_B_IN,
    // core side
    input wire logic INSTR_VALID_IN,
    input wire logic [9:0] INSTR_WORD_IN,
    input wire logic [3:0] ACC_IN,
    output logic ACC_LOAD_OUT,
    output logic [3:0] ACC_DATA_OUT,
    output logic HIT_OUT,
    output logic SKIP_OUT,
    output logic CARRY_WRITE_OUT,
    // controlled registers
    output ictd_wakeup_t WAKEUP_OUT,
    output ictd_format_t FORMAT_OUT,
    output ictd_clock_t CLOCK_OUT,
    // axi4-lite slave
    input wire logic [7:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic [7:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN
);

    // ==========================================================
    // decode
    function automatic logic is_op(input logic [9:0] w,
                                   input logic [9:0] op);
        is_op = (w == op);
    endfunction

    logic v;
    logic [9:0] w;
    assign v = INSTR_VALID_IN;
    assign w = INSTR_WORD_IN;

    logic hit_rd_k0, hit_rd_k1, hit_rd_k2, hit_rd_div;
    assign hit_rd_k0 = v && is_op(w, OP_READ_WAKEUP_CTL0);
    assign hit_rd_k1 = v && is_op(w, OP_READ_WAKEUP_CTL1);
    assign hit_rd_k2 = v && is_op(w, OP_READ_WAKEUP_CTL2);
    assign hit_rd_div = v && is_op(w, OP_READ_CLOCK_DIVISION);

    // format words are consecutive codes
    logic [3:0] hit_fmt;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_fmt
            assign hit_fmt[gi] = v && is_op(w,
                10'(OP_WRITE_OUT_FORMAT0 + gi));
        end
    endgenerate

    // hit line tells the core the word belonged to this group
    logic any_write;
    assign any_write = v && (is_op(w, OP_WRITE_WAKEUP_CTL0)
        || is_op(w, OP_WRITE_WAKEUP_CTL1)
        || is_op(w, OP_WRITE_WAKEUP_CTL2)
        || is_op(w, OP_SELECT_CERAMIC_OSC)
        || is_op(w, OP_SELECT_RC_OSC)
        || is_op(w, OP_SELECT_QUARTZ_OSC)
        || is_op(w, OP_WRITE_CLOCK_GATE_BIT)
        || is_op(w, OP_WRITE_CLOCK_DIVISION)
        || (|hit_fmt));

    // ==========================================================
    // accumulator load and group status
    logic rd_any;
    assign rd_any = hit_rd_k0 | hit_rd_k1 | hit_rd_k2 | hit_rd_div;
    logic [3:0] next_acc_data;
    // data output holds between loads
    always_comb begin
        next_acc_data = ACC_DATA_OUT;
        if (hit_rd_k0) begin
            next_acc_data = WAKEUP_OUT.wakeup_ctl0;
        end else if (hit_rd_k1) begin
            next_acc_data = WAKEUP_OUT.wakeup_ctl1;
        end else if (hit_rd_k2) begin
            next_acc_data = WAKEUP_OUT.wakeup_ctl2;
        end else if (hit_rd_div) begin
            next_acc_data = CLOCK_OUT.clock_division_ctl;
        end
    end

    // read beside a load of the same register returns the old value
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            ACC_LOAD_OUT <= 1'b0;
            ACC_DATA_OUT <= NIBBLE_RESET;
            HIT_OUT <= 1'b0;
        end else begin
            ACC_LOAD_OUT <= rd_any;
            ACC_DATA_OUT <= next_acc_data;
            HIT_OUT <= rd_any | any_write;
        end
    end

    // group never skips nor writes carry
    assign SKIP_OUT = 1'b0;
    assign CARRY_WRITE_OUT = 1'b0;

    // ==========================================================
    // wakeup registers
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            WAKEUP_OUT <= '0;
        end else if (v) begin
            if (is_op(w, OP_WRITE_WAKEUP_CTL0)) begin
                WAKEUP_OUT.wakeup_ctl0 <= ACC_IN;
            end
            if (is_op(w, OP_WRITE_WAKEUP_CTL1)) begin
                WAKEUP_OUT.wakeup_ctl1 <= ACC_IN;
            end
            if (is_op(w, OP_WRITE_WAKEUP_CTL2)) begin
                WAKEUP_OUT.wakeup_ctl2 <= ACC_IN;
            end
        end
    end

    // ==========================================================
    // output format registers, write only from the core
    // readable over the bus for observation only
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            FORMAT_OUT <= '0;
        end else begin
            if (hit_fmt[0]) begin
                FORMAT_OUT.out_format0 <= ACC_IN;
            end
            if (hit_fmt[1]) begin
                FORMAT_OUT.out_format1 <= ACC_IN;
            end
            if (hit_fmt[2]) begin
                FORMAT_OUT.out_format2 <= ACC_IN;
            end
            if (hit_fmt[3]) begin
                FORMAT_OUT.out_format3 <= ACC_IN;
            end
        end
    end

    // ==========================================================
    // clock control
    // one word per cycle, so at most one field changes
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            CLOCK_OUT.clock_division_ctl <= NIBBLE_RESET;
            CLOCK_OUT.clock_gate_ctl <= CLOCK_GATE_RESET;
            CLOCK_OUT.osc_select <= OSC_RESET;
        end else if (v) begin
            case (w)
                OP_SELECT_CERAMIC_OSC: begin
                    CLOCK_OUT.osc_select <= OSC_CERAMIC;
                end
                OP_SELECT_RC_OSC: begin
                    CLOCK_OUT.osc_select <= OSC_RC;
                end
                OP_SELECT_QUARTZ_OSC: begin
                    CLOCK_OUT.osc_select <= OSC_QUARTZ;
                end
                OP_WRITE_CLOCK_GATE_BIT: begin
                    CLOCK_OUT.clock_gate_ctl <= ACC_IN[0];
                end
                OP_WRITE_CLOCK_DIVISION: begin
                    CLOCK_OUT.clock_division_ctl <= ACC_IN;
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // axi4-lite write channel: registers are read-only, answer slverr
    // address, data and strobes are not needed: nothing is stored
    // aw and w are held until both have arrived
    logic aw_held, w_held;
    assign S_AXI_AWREADY_OUT = !aw_held && !S_AXI_BVALID_OUT;
    assign S_AXI_WREADY_OUT = !w_held && !S_AXI_BVALID_OUT;
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_BVALID_OUT <= 1'b0;
            S_AXI_BRESP_OUT <= RESP_OKAY;
        end else if (S_AXI_BVALID_OUT) begin
            if (S_AXI_BREADY_IN) begin
                S_AXI_BVALID_OUT <= 1'b0;
            end
        end else begin
            if ((aw_held || S_AXI_AWVALID_IN)
                && (w_held || S_AXI_WVALID_IN)) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                S_AXI_BVALID_OUT <= 1'b1;
                S_AXI_BRESP_OUT <= RESP_SLVERR;
            end else begin
                aw_held <= aw_held | S_AXI_AWVALID_IN;
                w_held <= w_held | S_AXI_WVALID_IN;
            end
        end
    end

    // ==========================================================
    // axi4-lite read channel
    // word slot of a byte address; the low two bits are ignored
    function automatic logic [7:0] word_slot(input logic [7:0] a);
        word_slot = {a[7:2], 2'h0};
    endfunction

    function automatic logic slot_mapped(input logic [7:0] a);
        case (word_slot(a))
            REG_WAKEUP_CTL0, REG_WAKEUP_CTL1, REG_WAKEUP_CTL2,
            REG_OUT_FORMAT0, REG_OUT_FORMAT1, REG_OUT_FORMAT2,
            REG_OUT_FORMAT3, REG_CLOCK_CTL, REG_STATUS: begin
                slot_mapped = 1'b1;
            end
            default: begin
                slot_mapped = 1'b0;
            end
        endcase
    endfunction

    function automatic logic [31:0] read_word(input logic [7:0] a);
        read_word = '0;
        case (word_slot(a))
            REG_WAKEUP_CTL0: read_word[3:0] = WAKEUP_OUT.wakeup_ctl0;
            REG_WAKEUP_CTL1: read_word[3:0] = WAKEUP_OUT.wakeup_ctl1;
            REG_WAKEUP_CTL2: read_word[3:0] = WAKEUP_OUT.wakeup_ctl2;
            REG_OUT_FORMAT0: read_word[3:0] = FORMAT_OUT.out_format0;
            REG_OUT_FORMAT1: read_word[3:0] = FORMAT_OUT.out_format1;
            REG_OUT_FORMAT2: read_word[3:0] = FORMAT_OUT.out_format2;
            REG_OUT_FORMAT3: read_word[3:0] = FORMAT_OUT.out_format3;
            REG_CLOCK_CTL: begin
                read_word[CLK_DIV_LSB +: 4] = CLOCK_OUT.clock_division_ctl;
                read_word[CLK_GATE_BIT] = CLOCK_OUT.clock_gate_ctl;
                read_word[OSC_SEL_LSB +: 2] = CLOCK_OUT.osc_select;
            end
            REG_STATUS: read_word[0] = HIT_OUT;
            default: begin
                read_word = '0;
            end
        endcase
    endfunction

    // one read at a time; data and response held until rready
    assign S_AXI_ARREADY_OUT = !S_AXI_RVALID_OUT;
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            S_AXI_RVALID_OUT <= 1'b0;
            S_AXI_RDATA_OUT <= '0;
            S_AXI_RRESP_OUT <= RESP_OKAY;
        end else if (S_AXI_RVALID_OUT) begin
            if (S_AXI_RREADY_IN) begin
                S_AXI_RVALID_OUT <= 1'b0;
            end
        end else if (S_AXI_ARVALID_IN) begin
            S_AXI_RDATA_OUT <= read_word(S_AXI_ARADDR_IN);
            if (slot_mapped(S_AXI_ARADDR_IN)) begin
                S_AXI_RRESP_OUT <= RESP_OKAY;
            end else begin
                S_AXI_RRESP_OUT <= RESP_SLVERR;
            end
            S_AXI_RVALID_OUT <= 1'b1;
        end
    end

endmodule

/* test/ictd_core_model.sv */
// Purpose: accumulator side of the core facing the decoder
// Assumes: bench presets the accumulator between instructions
// Notes: a load strobe from the decoder wins over a preset
`timescale 1ns/100ps
module ictd_core_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // bench side
    input wire logic preset_in,
    input wire logic [3:0] preset_val_in,
    // decoder side
    input wire logic acc_load_in,
    input wire logic [3:0] acc_data_in,
    output logic [3:0] acc_out
);
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            acc_out <= 4'h0;
        end else if (acc_load_in) begin
            acc_out <= acc_data_in;
        end else if (preset_in) begin
            acc_out <= preset_val_in;
        end
    end
endmodule

/* test/ictd_decoder_properties.sv */
// Purpose: timing relations of the decoder core side
// Assumes: one clock, sync active low reset
// Notes: bound to the decoder at the foot of this file
`timescale 1ns/100ps
module ictd_decoder_properties
    import ictd_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_B_IN,
    // core side
    input wire logic INSTR_VALID_IN,
    input wire logic [9:0] INSTR_WORD_IN,
    input wire logic [3:0] ACC_IN,
    input wire logic ACC_LOAD_OUT,
    input wire logic [3:0] ACC_DATA_OUT,
    input wire logic HIT_OUT,
    input wire logic SKIP_OUT,
    input wire logic CARRY_WRITE_OUT,
    // controlled registers
    input wire ictd_wakeup_t WAKEUP_OUT,
    input wire ictd_format_t FORMAT_OUT,
    input wire ictd_clock_t CLOCK_OUT
);
    logic grp;
    logic v;
    assign v = INSTR_VALID_IN;
    assign grp = INSTR_WORD_IN inside {OP_READ_WAKEUP_CTL0,
        OP_WRITE_WAKEUP_CTL0, OP_READ_WAKEUP_CTL1, OP_WRITE_WAKEUP_CTL1,
        OP_READ_WAKEUP_CTL2, OP_WRITE_WAKEUP_CTL2, OP_WRITE_OUT_FORMAT0,
        OP_WRITE_OUT_FORMAT1, OP_WRITE_OUT_FORMAT2, OP_WRITE_OUT_FORMAT3,
        OP_SELECT_CERAMIC_OSC, OP_SELECT_RC_OSC, OP_SELECT_QUARTZ_OSC,
        OP_WRITE_CLOCK_GATE_BIT, OP_READ_CLOCK_DIVISION,
        OP_WRITE_CLOCK_DIVISION};
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    chk_hit_taken:
    assert property (v && grp |=> HIT_OUT) else $error("hit missing");
    chk_outside_quiet:
    assert property (!(v && grp) |=> !HIT_OUT && !ACC_LOAD_OUT &&
        $stable(WAKEUP_OUT) && $stable(FORMAT_OUT) && $stable(CLOCK_OUT))
        else $error("register changed outside group");
    chk_read_ctl0:
    assert property (v && INSTR_WORD_IN == OP_READ_WAKEUP_CTL0 |=>
        ACC_LOAD_OUT && ACC_DATA_OUT == $past(WAKEUP_OUT.wakeup_ctl0))
        else $error("wakeup 0 read wrong");
    chk_read_div:
    assert property (v && INSTR_WORD_IN == OP_READ_CLOCK_DIVISION |=>
        ACC_LOAD_OUT ##0 ACC_DATA_OUT == $past(CLOCK_OUT.clock_division_ctl))
        else $error("division read wrong");
    chk_write_ctl1:
    assert property (v && INSTR_WORD_IN == OP_WRITE_WAKEUP_CTL1 |=>
        WAKEUP_OUT.wakeup_ctl1 == $past(ACC_IN)) else $error("wakeup 1 load");
    chk_format_three:
    assert property (v && INSTR_WORD_IN == OP_WRITE_OUT_FORMAT3 |=>
        FORMAT_OUT.out_format3 == $past(ACC_IN)) else $error("format 3 load");
    chk_osc_quartz:
    assert property (v && INSTR_WORD_IN == OP_SELECT_QUARTZ_OSC |=>
        CLOCK_OUT.osc_select == OSC_QUARTZ) else $error("quartz not chosen");
    chk_gate_bit:
    assert property (v && INSTR_WORD_IN == OP_WRITE_CLOCK_GATE_BIT |=>
        CLOCK_OUT.clock_gate_ctl == $past(ACC_IN[0]) &&
        $stable(CLOCK_OUT.clock_division_ctl)) else $error("gate bit load");
    chk_no_skip:
    assert property (!SKIP_OUT && !CARRY_WRITE_OUT)
        else $error("skip or carry");
endmodule
bind ictd_decoder ictd_decoder_properties ictd_decoder_properties_i (
    .REF_CLK_IN, .RST_B_IN, .INSTR_VALID_IN, .INSTR_WORD_IN, .ACC_IN,
    .ACC_LOAD_OUT, .ACC_DATA_OUT, .HIT_OUT, .SKIP_OUT, .CARRY_WRITE_OUT,
    .WAKEUP_OUT, .FORMAT_OUT, .CLOCK_OUT);

/* test/ictd_decoder_test.sv */
// Purpose: self-checking bench for the transfer decoder
// Assumes: registers observed read-only over the bus
// Notes: core accumulator kept by the partner model
`timescale 1ns/100ps
module ictd_decoder_test;
    import ictd_pkg::*;
    logic REF_CLK_IN = 1'b0, RST_B_IN = 1'b0, INSTR_VALID_IN = 1'b0;
    logic preset = 1'b0, S_AXI_AWVALID_IN = 1'b0, S_AXI_WVALID_IN = 1'b0;
    logic S_AXI_BREADY_IN = 1'b0, S_AXI_ARVALID_IN = 1'b0;
    logic S_AXI_RREADY_IN = 1'b0;
    logic [9:0] INSTR_WORD_IN = 10'h000;
    logic [3:0] pval = 4'h0, S_AXI_WSTRB_IN = 4'hF, ACC_IN, ACC_DATA_OUT;
    logic [7:0] S_AXI_AWADDR_IN = 8'h00, S_AXI_ARADDR_IN = 8'h00;
    logic [31:0] S_AXI_WDATA_IN = 32'h0, S_AXI_RDATA_OUT, rd;
    logic [1:0] S_AXI_BRESP_OUT, S_AXI_RRESP_OUT, rs;
    logic ACC_LOAD_OUT, HIT_OUT, SKIP_OUT, CARRY_WRITE_OUT, S_AXI_AWREADY_OUT;
    logic S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT;
    logic S_AXI_RVALID_OUT;
    ictd_wakeup_t WAKEUP_OUT;
    ictd_format_t FORMAT_OUT;
    ictd_clock_t CLOCK_OUT;
    int err_total = 0;
    int n_compared = 0;
    logic [9:0] wr_op [3] = '{OP_WRITE_WAKEUP_CTL0, OP_WRITE_WAKEUP_CTL1,
        OP_WRITE_WAKEUP_CTL2};
    logic [9:0] rd_op [3] = '{OP_READ_WAKEUP_CTL0, OP_READ_WAKEUP_CTL1,
        OP_READ_WAKEUP_CTL2};
    logic [9:0] osc_op [3] = '{OP_SELECT_RC_OSC, OP_SELECT_QUARTZ_OSC,
        OP_SELECT_CERAMIC_OSC};
    logic [1:0] osc_code [3] = '{OSC_RC, OSC_QUARTZ, OSC_CERAMIC};
    always #2.5 REF_CLK_IN = ~REF_CLK_IN;
    ictd_decoder ictd_decoder_i (.REF_CLK_IN, .RST_B_IN, .INSTR_VALID_IN,
        .INSTR_WORD_IN, .ACC_IN, .ACC_LOAD_OUT, .ACC_DATA_OUT, .HIT_OUT,
        .SKIP_OUT, .CARRY_WRITE_OUT, .WAKEUP_OUT, .FORMAT_OUT, .CLOCK_OUT,
        .S_AXI_AWADDR_IN, .S_AXI_AWVALID_IN, .S_AXI_AWREADY_OUT,
        .S_AXI_WDATA_IN, .S_AXI_WSTRB_IN, .S_AXI_WVALID_IN, .S_AXI_WREADY_OUT,
        .S_AXI_BRESP_OUT, .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN,
        .S_AXI_ARADDR_IN, .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT,
        .S_AXI_RDATA_OUT, .S_AXI_RRESP_OUT, .S_AXI_RVALID_OUT,
        .S_AXI_RREADY_IN);
    ictd_core_model ictd_core_model_i (.clk_in(REF_CLK_IN),
        .rst_b_in(RST_B_IN), .preset_in(preset), .preset_val_in(pval),
        .acc_load_in(ACC_LOAD_OUT), .acc_data_in(ACC_DATA_OUT),
        .acc_out(ACC_IN));
    task automatic end_of_test();
        if (err_total == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_hi(ref logic s);
        int n = 0;
        @(posedge REF_CLK_IN);
        while (s !== 1'b1) begin
            n++;
            if (n > 50) begin
                err_total++;
                end_of_test();
            end
            @(posedge REF_CLK_IN);
        end
    endtask
    // two words back to back after an accumulator preset
    task automatic op(logic [3:0] a, logic [9:0] w1, logic [9:0] w2);
        pval <= a;
        preset <= 1'b1;
        @(posedge REF_CLK_IN);
        preset <= 1'b0;
        INSTR_VALID_IN <= 1'b1;
        INSTR_WORD_IN <= w1;
        @(posedge REF_CLK_IN);
        INSTR_WORD_IN <= w2;
        @(posedge REF_CLK_IN);
        INSTR_VALID_IN <= 1'b0;
        repeat (2) @(posedge REF_CLK_IN);
    endtask
    task automatic axi_rd(logic [7:0] a);
        S_AXI_ARADDR_IN <= a;
        S_AXI_ARVALID_IN <= 1'b1;
        S_AXI_RREADY_IN <= 1'b1;
        wait_hi(S_AXI_ARREADY_OUT);
        S_AXI_ARVALID_IN <= 1'b0;
        wait_hi(S_AXI_RVALID_OUT);
        rd = S_AXI_RDATA_OUT;
        rs = S_AXI_RRESP_OUT;
        S_AXI_RREADY_IN <= 1'b0;
        @(posedge REF_CLK_IN);
    endtask
    task automatic axi_wr(logic [7:0] a);
        int n = 0;
        logic aw_busy = 1'b1;
        logic w_busy = 1'b1;
        S_AXI_AWADDR_IN <= a;
        S_AXI_WDATA_IN <= 32'hFFFFFFFF;
        S_AXI_AWVALID_IN <= 1'b1;
        S_AXI_WVALID_IN <= 1'b1;
        S_AXI_BREADY_IN <= 1'b1;
        while ((aw_busy || w_busy) && n < 50) begin
            @(posedge REF_CLK_IN);
            n++;
            if (aw_busy && S_AXI_AWREADY_OUT) begin
                S_AXI_AWVALID_IN <= 1'b0;
                aw_busy = 1'b0;
            end
            if (w_busy && S_AXI_WREADY_OUT) begin
                S_AXI_WVALID_IN <= 1'b0;
                w_busy = 1'b0;
            end
        end
        if (aw_busy || w_busy) begin
            err_total++;
            end_of_test();
        end
        wait_hi(S_AXI_BVALID_OUT);
        rs = S_AXI_BRESP_OUT;
        S_AXI_BREADY_IN <= 1'b0;
    endtask
    initial begin
        repeat (16) @(posedge REF_CLK_IN);
        RST_B_IN <= 1'b1;
        @(posedge REF_CLK_IN);
        for (int i = 0; i < 9; i++) begin
            axi_rd(8'(4 * i));
            cmp("reset value", 32'h0, rd);
        end
        for (int i = 0; i < 3; i++) begin
            op(4'(i + 5), wr_op[i], 10'h3FF);
            op(4'h0, rd_op[i], wr_op[i]);
            cmp("acc after read", 32'(i + 5), {28'h0, ACC_IN});
            axi_rd(8'(4 * i));
            cmp("wakeup after load", 32'h0, rd);
        end
        for (int i = 0; i < 4; i++) begin
            op(4'(i + 9), OP_WRITE_OUT_FORMAT0 + 10'(i), 10'h3FF);
            axi_rd(REG_OUT_FORMAT0 + 8'(4 * i));
            cmp("format", 32'(i + 9), rd);
        end
        op(4'h7, OP_WRITE_CLOCK_DIVISION, OP_WRITE_CLOCK_GATE_BIT);
        op(4'h0, OP_READ_CLOCK_DIVISION, 10'h3FF);
        cmp("division to acc", 32'h7, {28'h0, ACC_IN});
        axi_rd(REG_CLOCK_CTL);
        cmp("clock ctl", 32'h17, rd);
        op(4'hE, OP_WRITE_CLOCK_GATE_BIT, 10'h3FF);
        for (int i = 0; i < 3; i++) begin
            op(4'h0, osc_op[i], 10'h3FF);
            axi_rd(REG_CLOCK_CTL);
            cmp("osc select", {22'h0, osc_code[i], 8'h07}, rd);
        end
        op(4'hF, 10'h01B, 10'h3D6);
        cmp("acc near miss", 32'hF, {28'h0, ACC_IN});
        axi_rd(REG_WAKEUP_CTL0);
        cmp("near miss word", 32'h0, rd);
        axi_rd(8'h40);
        cmp("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        cmp("unmapped data", 32'h0, rd);
        axi_wr(REG_WAKEUP_CTL0);
        cmp("write resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        axi_rd(REG_WAKEUP_CTL0);
        cmp("after bus write", 32'h0, rd);
        end_of_test();
    end
endmodule
